/* inc/dac_update_defines.svh */
// offsets, field positions and reset values for the dac update control
// Behaviour
// - per-channel enable; disabled channel output off
// - update source select in control bits 6:4
// - codes 000-011 latch on timer 0-3 overflow
// - code 100 latches on pin rising edge
// - code 101 latches on pin falling edge
// - code 110 latches on any pin edge
// - default 111: high byte write latches both
// - timer/pin modes hold writes until event
// - justify 0 means left-justified word
// - justify 1 (bit 2) means right-justified word
// - range bits 1:0, 00 gives 0.25 mA
// - range 01 gives 0.5 mA
// - range 10 gives 1.0 mA
// - range 11 gives 2.0 mA
// - reset range is 2 mA
`ifndef DAC_UPDATE_DEFINES_SVH
`define DAC_UPDATE_DEFINES_SVH
`define OFS_DAC0_CONTROL   8'hB9
`define OFS_DAC0_DATA_LOW  8'hBA
`define OFS_DAC0_DATA_HIGH 8'hBB
`define OFS_DAC1_CONTROL   8'hBC
`define OFS_DAC1_DATA_LOW  8'hBD
`define OFS_DAC1_DATA_HIGH 8'hBE
`define OFS_DAC_STATUS     8'hBF
`define CTRL_RESET         8'h73
`define CTRL_WRITE_MASK    8'hF7
`define BIT_ENABLE         7
`define BIT_JUSTIFY        2
`define SRC_HI             6
`define SRC_LO             4
`define RANGE_HI           1
`define RANGE_LO           0
`endif

/* inc/dac_update_pkg.sv */
// types for the dac update control
package dac_update_pkg;
   typedef enum logic [2:0] {
      SRC_TIMER0, SRC_TIMER1, SRC_TIMER2, SRC_TIMER3,
      SRC_PIN_RISE, SRC_PIN_FALL, SRC_PIN_ANY, SRC_ON_WRITE
   } update_source_t;
   typedef enum logic [1:0] {
      RANGE_0P25MA, RANGE_0P5MA, RANGE_1MA, RANGE_2MA
   } fullscale_range_t;
endpackage : dac_update_pkg

/* rtl/dac_channel.sv */
// one dac channel: control register, held data, converter latch
`timescale 1ns/100ps
`include "dac_update_defines.svh"
module dac_channel
   import dac_update_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        wr_ctrl,
   input  wire logic        wr_low,
   input  wire logic        wr_high,
   input  wire logic [7:0]  wdata,
   input  wire logic [3:0]  timer_overflow,
   input  wire logic        pin_rise,
   input  wire logic        pin_fall,
   output logic      [7:0]  control,
   output logic      [7:0]  data_low,
   output logic      [7:0]  data_high,
   output logic      [11:0] dac_code,
   output logic             dac_enable,
   output logic      [1:0]  fullscale_range,
   output logic             update_pulse
);
   update_source_t  source;
   logic            event_hit;
   logic            right_justify;
   logic [11:0]     word;

   assign source        = update_source_t'(control[`SRC_HI:`SRC_LO]);
   assign right_justify = control[`BIT_JUSTIFY];
   assign dac_enable    = control[`BIT_ENABLE];
   assign fullscale_range = control[`RANGE_HI:`RANGE_LO];

   always_comb
   begin
      case (source)
         SRC_TIMER0:   event_hit = timer_overflow[0];
         SRC_TIMER1:   event_hit = timer_overflow[1];
         SRC_TIMER2:   event_hit = timer_overflow[2];
         SRC_TIMER3:   event_hit = timer_overflow[3];
         SRC_PIN_RISE: event_hit = pin_rise;
         SRC_PIN_FALL: event_hit = pin_fall;
         SRC_PIN_ANY:  event_hit = pin_rise | pin_fall;
         SRC_ON_WRITE: event_hit = wr_high;
         default:      event_hit = 1'b0;
      endcase
   end

   // on-write mode uses the new high byte written in this very cycle
   logic [7:0] high_now;
   assign high_now = (wr_high) ? wdata : data_high;
   assign word = right_justify ? {high_now[3:0], data_low}
                               : {high_now, data_low[7:4]};
   assign update_pulse = event_hit;

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         control   <= `CTRL_RESET;
         data_low  <= 8'h00;
         data_high <= 8'h00;
         dac_code  <= 12'h000;
      end
      else
      begin
         if (wr_ctrl)
            control <= wdata & `CTRL_WRITE_MASK;
         if (wr_low)
            data_low <= wdata;
         if (wr_high)
            data_high <= wdata;
         if (event_hit)
            dac_code <= word;
      end
   end

   AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
      control[3] == 1'b0) else $error("reserved control bit set");
   AST_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
      !event_hit |=> $stable(dac_code)) else $error("dac code changed without event");
   AST_ONWRITE: assert property (@(posedge clk) disable iff (!rst_b)
      (source == SRC_ON_WRITE && wr_high && !right_justify)
      |=> dac_code[11:4] == $past(wdata)) else $error("high write not latched");
   AST_LOWONLY: assert property (@(posedge clk) disable iff (!rst_b)
      (source == SRC_ON_WRITE && wr_low && !wr_high) |=> $stable(dac_code))
      else $error("low write alone reached dac");
   AST_RISE: assert property (@(posedge clk) disable iff (!rst_b)
      (source == SRC_PIN_RISE && pin_rise && !wr_high && !wr_low)
      |=> dac_code == $past(right_justify ? {data_high[3:0], data_low}
                                          : {data_high, data_low[7:4]}))
      else $error("rise edge update missing");
   AST_TIMER: assert property (@(posedge clk) disable iff (!rst_b)
      (source == SRC_TIMER2 && !timer_overflow[2]) |=> $stable(dac_code))
      else $error("timer 2 mode updated without overflow");
endmodule : dac_channel

/* rtl/current_dac_update_control.sv */
// two-channel current dac update control with register port
`timescale 1ns/100ps
`include "dac_update_defines.svh"
module current_dac_update_control
   import dac_update_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic [7:0]  addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   output logic      [7:0]  rdata,
   input  wire logic [3:0]  timer_overflow,
   input  wire logic        conversion_start_pin,
   output logic      [11:0] channel0_code,
   output logic      [11:0] channel1_code,
   output logic             channel0_enable,
   output logic             channel1_enable,
   output logic      [1:0]  channel0_fullscale_range,
   output logic      [1:0]  channel1_fullscale_range
);
   logic       pin_meta;
   logic       pin_sync;
   logic       pin_last;
   logic       pin_rise;
   logic       pin_fall;
   logic [7:0] ctrl0, low0, high0, ctrl1, low1, high1;
   logic [11:0] code0, code1;
   logic       en0, en1;
   logic [1:0] rng0, rng1;
   logic       upd0, upd1;
   logic [7:0] next_rdata;
   logic [7:0] status;

   // pin synchroniser and edge detect
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         pin_meta <= 1'b0;
         pin_sync <= 1'b0;
         pin_last <= 1'b0;
      end
      else
      begin
         pin_meta <= conversion_start_pin;
         pin_sync <= pin_meta;
         pin_last <= pin_sync;
      end
   end
   assign pin_rise = pin_sync & ~pin_last;
   assign pin_fall = ~pin_sync & pin_last;

   logic wr_c0, wr_l0, wr_h0, wr_c1, wr_l1, wr_h1;
   assign wr_c0 = wr_en && addr == `OFS_DAC0_CONTROL;
   assign wr_l0 = wr_en && addr == `OFS_DAC0_DATA_LOW;
   assign wr_h0 = wr_en && addr == `OFS_DAC0_DATA_HIGH;
   assign wr_c1 = wr_en && addr == `OFS_DAC1_CONTROL;
   assign wr_l1 = wr_en && addr == `OFS_DAC1_DATA_LOW;
   assign wr_h1 = wr_en && addr == `OFS_DAC1_DATA_HIGH;

   dac_channel u_ch0 (
      .clk(clk), .rst_b(rst_b), .wr_ctrl(wr_c0), .wr_low(wr_l0), .wr_high(wr_h0),
      .wdata(wdata), .timer_overflow(timer_overflow), .pin_rise(pin_rise),
      .pin_fall(pin_fall), .control(ctrl0), .data_low(low0), .data_high(high0),
      .dac_code(code0), .dac_enable(en0), .fullscale_range(rng0), .update_pulse(upd0)
   );
   dac_channel u_ch1 (
      .clk(clk), .rst_b(rst_b), .wr_ctrl(wr_c1), .wr_low(wr_l1), .wr_high(wr_h1),
      .wdata(wdata), .timer_overflow(timer_overflow), .pin_rise(pin_rise),
      .pin_fall(pin_fall), .control(ctrl1), .data_low(low1), .data_high(high1),
      .dac_code(code1), .dac_enable(en1), .fullscale_range(rng1), .update_pulse(upd1)
   );

   // disabled channel drives zero code
   assign channel0_code = en0 ? code0 : 12'h000;
   assign channel1_code = en1 ? code1 : 12'h000;
   assign channel0_enable = en0;
   assign channel1_enable = en1;
   assign channel0_fullscale_range = rng0;
   assign channel1_fullscale_range = rng1;

   assign status = {6'h00, pin_sync, en0 | en1};

   always_comb
   begin
      case (addr)
         `OFS_DAC0_CONTROL:   next_rdata = ctrl0;
         `OFS_DAC0_DATA_LOW:  next_rdata = low0;
         `OFS_DAC0_DATA_HIGH: next_rdata = high0;
         `OFS_DAC1_CONTROL:   next_rdata = ctrl1;
         `OFS_DAC1_DATA_LOW:  next_rdata = low1;
         `OFS_DAC1_DATA_HIGH: next_rdata = high1;
         `OFS_DAC_STATUS:     next_rdata = status;
         default:             next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
         rdata <= 8'h00;
      else if (rd_en)
         rdata <= next_rdata;
      else
         rdata <= 8'h00;
   end

   AST_DISABLED_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
      !channel0_enable |-> channel0_code == 12'h000) else $error("disabled ch0 drives");
   AST_ANY_EDGE: assert property (@(posedge clk) disable iff (!rst_b)
      (ctrl1[6:4] == 3'h6 && pin_fall) |-> upd1) else $error("any-edge missed fall");
   AST_HIGH_WRITE_UPD: assert property (@(posedge clk) disable iff (!rst_b)
      (ctrl0[6:4] == 3'h7 && wr_h0) |-> upd0) else $error("high write gave no update");
   AST_RESET_RANGE: assert property (@(posedge clk)
      !rst_b |=> channel0_fullscale_range == 2'h3 && channel1_fullscale_range == 2'h3)
      else $error("range not 2 mA after reset");
endmodule : current_dac_update_control

/* testbench/test_current_dac_update_control.sv */
// self-checking bench for the two-channel dac update control
`timescale 1ns/100ps
module test_current_dac_update_control;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [7:0]  wdata = 8'h00;
   logic        wr_en = 1'b0;
   logic        rd_en = 1'b0;
   logic [7:0]  rdata;
   logic [3:0]  tmr = 4'h0;
   logic        pin = 1'b0;
   logic [11:0] code0;
   logic [11:0] code1;
   logic        en0;
   logic        en1;
   logic [1:0]  rng0;
   logic [1:0]  rng1;
   logic [11:0] exp1 = 12'h000;
   logic [7:0]  d;
   int          error_cnt = 0;
   int          check_count = 0;

   current_dac_update_control dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .timer_overflow(tmr),
      .conversion_start_pin(pin), .channel0_code(code0), .channel1_code(code1),
      .channel0_enable(en0), .channel1_enable(en1),
      .channel0_fullscale_range(rng0), .channel1_fullscale_range(rng1));

   initial
   begin
      forever #20 clk = ~clk;
   end

   task check(input string what, input logic [11:0] exp, input logic [11:0] got);
      check_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      addr  <= a;
      wdata <= v;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask : wr

   task rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 check("rdata", {4'h0, exp}, {4'h0, rdata});
   endtask : rd

   task settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : settle

   task pulse(input int n);
      @(posedge clk);
      tmr <= 4'h1 << n;
      @(posedge clk);
      tmr <= 4'h0;
   endtask : pulse

   task end_sim;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_sim

   initial
   begin
      #2000000;
      error_cnt++;
      end_sim();
   end

   initial
   begin
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      rd(8'hB9, 8'h73);
      rd(8'hBC, 8'h73);
      check("range0", 12'h003, {10'h0, rng0});
      check("enable0", 12'h000, {11'h0, en0});
      rd(8'hC0, 8'h00);
      wr(8'hB9, 8'hFF);
      rd(8'hB9, 8'hF7);
      wr(8'hBA, 8'hA4);
      settle(2);
      check("code0", 12'h000, code0);
      wr(8'hBB, 8'h5C);
      settle(2);
      check("code0", 12'hCA4, code0);
      wr(8'hB9, 8'hF0);
      wr(8'hBB, 8'h5C);
      settle(2);
      check("code0", 12'h5CA, code0);
      check("range0", 12'h000, {10'h0, rng0});
      wr(8'hB9, 8'h70);
      settle(2);
      check("code0", 12'h000, code0);
      for (int n = 0; n < 4; n++)
      begin
         wr(8'hBC, 8'h80 | 8'(n << 4) | 8'(n));
         wr(8'hBD, {4'(n), 4'h0});
         wr(8'hBE, 8'hA0 + 8'(n));
         pulse((n + 1) % 4);
         settle(2);
         check("code1", exp1, code1);
         pulse(n);
         settle(2);
         exp1 = {8'hA0 + 8'(n), 4'(n)};
         check("code1", exp1, code1);
         check("range1", {10'h0, 2'(n)}, {10'h0, rng1});
         check("enable1", 12'h001, {11'h0, en1});
      end
      for (int m = 0; m < 3; m++)
      begin
         wr(8'hBC, 8'h83 | 8'((4 + m) << 4));
         for (int k = 0; k < 2; k++)
         begin
            d = 8'h30 + 8'(m * 2 + k);
            wr(8'hBE, d);
            @(posedge clk);
            pin <= ~pin;
            settle(6);
            if ((k == 0 && m != 1) || (k == 1 && m != 0))
               exp1 = {d, 4'h3};
            check("code1", exp1, code1);
         end
      end
      rd(8'hBF, 8'h01);
      end_sim();
   end
endmodule : test_current_dac_update_control
